/* design/mic_interrupt_controller.sv */
`timescale 1ns/10ps
`include "mic_cfg.svh"

module mic_interrupt_controller
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [`MIC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`MIC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic ext_irq0,
    input wire logic ext_irq1,
    // timers
    input wire logic timer0_ovf,
    input wire logic timer_counter0_ovf,
    input wire logic timer1_ovf,
    // core sequencer
    input wire logic insn_boundary,
    input wire logic irq_return,
    input wire logic power_down,
    input wire logic green_mode,
    input wire logic ctx_save,
    input wire logic ctx_restore,
    input wire mic_pkg::mic_byte_t acc_in,
    input wire mic_pkg::mic_byte_t program_flag_reg_in,
    output mic_pkg::mic_byte_t acc_restore,
    output mic_pkg::mic_byte_t program_flag_reg_restore,
    output logic restore_valid,
    output logic pc_load,
    output logic [`MIC_PC_W-1:0] pc_vector,
    output logic [`MIC_STK_HI:0] stack_level,
    output logic global_irq_enable,
    output logic wake_up
);
    import mic_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mic_edge_if eif ();
    mic_state_t state;             // vectoring sequencer
    mic_byte_t interrupt_request_flags;
    mic_byte_t interrupt_enable_reg;
    logic [1:0] ext0_edge_select;
    mic_byte_t events;             // this cycle's source events
    logic aw_held;                 // write address captured
    logic w_held;                  // write data captured
    logic [`MIC_ADDR_W-3:0] aw_idx;
    mic_byte_t w_byte;
    logic w_lane;                  // low byte lane enabled
    logic wr_fire;                 // register write this cycle
    logic [`MIC_ADDR_W-3:0] ar_idx;
    logic accept;                  // vector taken this cycle
    logic asleep;
    mic_byte_t save_acc;           // one-level context buffer
    mic_byte_t save_program_flag_reg;

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    mic_edge_detect u_edge
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_irq0(ext_irq0),
        .ext_irq1(ext_irq1),
        .eif(eif.det)
    );

    assign eif.edge_sel = ext0_edge_select;

    // gather events into flag layout
    always_comb
    begin
        events = 8'h00;
        events[`MIC_BIT_EXT0] = eif.ext0_event;
        events[`MIC_BIT_EXT1] = eif.ext1_event;
        events[`MIC_BIT_T0] = timer0_ovf;
        events[`MIC_BIT_TC0] = timer_counter0_ovf;
        events[`MIC_BIT_T1] = timer1_ovf;
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // address channel, ready drops while a write is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_idx <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[`MIC_ADDR_W-1:2];
        end
        else if (wr_fire)
            aw_held <= 1'b0;
        else if (!aw_held && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
    end

    // data channel, independent of address order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end
        else if (wr_fire)
            w_held <= 1'b0;
        else if (!w_held && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
    end

    // write response, decode error for unmapped index
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MIC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx)
                `MIC_IDX_EDGE_SEL, `MIC_IDX_REQ_FLAGS,
                `MIC_IDX_ENABLE, `MIC_IDX_STACK_GIE:
                    s_axi_bresp <= `MIC_RESP_OKAY;
                default: s_axi_bresp <= `MIC_RESP_DECERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // edge select and per-source enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext0_edge_select <= `MIC_EDGE_RESET;
            interrupt_enable_reg <= 8'h00;
        end
        else if (wr_fire && w_lane)
        begin
            if (aw_idx == `MIC_IDX_EDGE_SEL)
                ext0_edge_select <= w_byte[`MIC_EDGE_HI:`MIC_EDGE_LO];
            if (aw_idx == `MIC_IDX_ENABLE)
                interrupt_enable_reg <= w_byte & `MIC_SRC_MASK;
        end
    end

    // ------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------
    // events set regardless of enables; a set beats a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            interrupt_request_flags <= 8'h00;
        else if (wr_fire && w_lane && aw_idx == `MIC_IDX_REQ_FLAGS)
            interrupt_request_flags <= (w_byte | events)
                & `MIC_SRC_MASK;
        else
            interrupt_request_flags <= (interrupt_request_flags | events)
                & `MIC_SRC_MASK;
    end

    // ------------------------------------------------------------
    // vector acceptance
    // ------------------------------------------------------------
    assign asleep = power_down || green_mode;

    // enabled pending flag with global enable, no priority among them
    assign accept = (state == MIC_RUN) && insn_boundary && !asleep
        && global_irq_enable
        && |(interrupt_request_flags & interrupt_enable_reg);

    // sequencer: run, sleep with flags held, one-cycle take
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= MIC_RUN;
        else
        begin
            case (state)
                MIC_RUN:
                    if (asleep)
                        state <= MIC_SLEEP;
                    else if (accept)
                        state <= MIC_TAKE;
                MIC_TAKE:
                    state <= asleep ? MIC_SLEEP : MIC_RUN;
                MIC_SLEEP:
                    if (!asleep)
                        state <= MIC_RUN;
                default:
                    state <= MIC_RUN;
            endcase
        end
    end

    // program counter redirect, one pulse per accepted request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_load <= 1'b0;
            pc_vector <= `MIC_VECTOR;
        end
        else
        begin
            pc_load <= accept;
            pc_vector <= `MIC_VECTOR;
        end
    end

    // ------------------------------------------------------------
    // stack pointer and global enable
    // ------------------------------------------------------------
    // pointer counts down from empty; hardware beats software writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_irq_enable <= 1'b0;
            stack_level <= `MIC_STK_RESET;
        end
        else if (accept)
        begin
            global_irq_enable <= 1'b0;
            stack_level <= stack_level - `MIC_STK_ONE;
        end
        else if (irq_return)
        begin
            global_irq_enable <= 1'b1;
            stack_level <= stack_level + `MIC_STK_ONE;
        end
        else if (wr_fire && w_lane && aw_idx == `MIC_IDX_STACK_GIE)
        begin
            global_irq_enable <= w_byte[`MIC_BIT_GIE];
            stack_level <= w_byte[`MIC_STK_HI:0];
        end
    end

    // ------------------------------------------------------------
    // wake-up from power down or green mode
    // ------------------------------------------------------------
    // qualified pin edges wake the core; the flag is already latched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_up <= 1'b0;
        else
            wake_up <= asleep
                && (eif.ext0_event || eif.ext1_event);
    end

    // ------------------------------------------------------------
    // context save buffer
    // ------------------------------------------------------------
    // single level; each save overwrites, reset-cause bits never kept
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            save_acc <= 8'h00;
            save_program_flag_reg <= 8'h00;
        end
        else if (ctx_save)
        begin
            save_acc <= acc_in;
            save_program_flag_reg <= program_flag_reg_in & `MIC_PROGRAM_FLAG_REG_KEEP;
        end
    end

    // restore presents stored values for one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_restore <= 8'h00;
            program_flag_reg_restore <= 8'h00;
            restore_valid <= 1'b0;
        end
        else
        begin
            restore_valid <= ctx_restore;
            if (ctx_restore)
            begin
                acc_restore <= save_acc;
                program_flag_reg_restore <= save_program_flag_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    assign ar_idx = s_axi_araddr[`MIC_ADDR_W-1:2];

    // one read at a time; ready returns after the data is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MIC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MIC_RESP_OKAY;
            case (ar_idx)
                `MIC_IDX_EDGE_SEL:
                    s_axi_rdata <= {27'h0000000, ext0_edge_select,
                        3'h0};
                `MIC_IDX_REQ_FLAGS:
                    s_axi_rdata <= {24'h000000, interrupt_request_flags};
                `MIC_IDX_ENABLE:
                    s_axi_rdata <= {24'h000000, interrupt_enable_reg};
                `MIC_IDX_STACK_GIE:
                    s_axi_rdata <= {24'h000000, global_irq_enable,
                        4'h0, stack_level};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `MIC_RESP_DECERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

endmodule // mic_interrupt_controller

/* design/mic_cfg.svh */
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// register indices; byte address is four times the index
`define MIC_IDX_EDGE_SEL 10'h0bf
`define MIC_IDX_REQ_FLAGS 10'h0c8
`define MIC_IDX_ENABLE 10'h0c9
`define MIC_IDX_STACK_GIE 10'h0df
`define MIC_ADDR_W 12

// flag and enable bit positions
`define MIC_BIT_EXT0 0
`define MIC_BIT_EXT1 1
`define MIC_BIT_T0 4
`define MIC_BIT_TC0 5
`define MIC_BIT_T1 6
`define MIC_SRC_MASK 8'h73

// stack pointer register fields
`define MIC_BIT_GIE 7
`define MIC_STK_HI 2
`define MIC_STK_RESET 3'h7
`define MIC_STK_ONE 3'h1

// edge select field
`define MIC_EDGE_HI 4
`define MIC_EDGE_LO 3
`define MIC_EDGE_RESET 2'h2
`define MIC_EDGE_RISE 2'h1
`define MIC_EDGE_FALL 2'h2
`define MIC_EDGE_BOTH 2'h3

// program flag bits kept by save and restore (reset-cause bits excluded)
`define MIC_PROGRAM_FLAG_REG_KEEP 8'h3f

// interrupt vector
`define MIC_PC_W 12
`define MIC_VECTOR 12'h008

// bus responses
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_DECERR 2'h3

`endif

/* design/mic_pkg.sv */
package mic_pkg;

    // vectoring sequencer states, one-hot
    typedef enum logic [2:0] {
        MIC_RUN = 3'h1,
        MIC_TAKE = 3'h2,
        MIC_SLEEP = 3'h4
    } mic_state_t;

    typedef logic [7:0] mic_byte_t;

endpackage

/* design/mic_edge_if.sv */
`timescale 1ns/10ps
// carries edge configuration out and qualified pin events back
interface mic_edge_if;
    logic [1:0] edge_sel;   // ext_irq0 edge choice
    logic ext0_event;       // one-cycle pulse per matching ext_irq0 edge
    logic ext1_event;       // one-cycle pulse per ext_irq1 falling edge

    modport det (input edge_sel, output ext0_event, output ext1_event);
    modport ctl (output edge_sel, input ext0_event, input ext1_event);
endinterface

/* design/mic_edge_detect.sv */
`timescale 1ns/10ps
`include "mic_cfg.svh"

module mic_edge_detect
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_irq0,
    input wire logic ext_irq1,
    mic_edge_if.det eif
);
    import mic_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] meta;   // first stage, read only by second stage
    logic [1:0] sync;   // second stage
    logic [1:0] prev;   // delayed copy for edge finding
    logic [1:0] rise;
    logic [1:0] fall;

    // two flops per pin, then one history flop
    // the chain keeps sampling through reset, so the history already
    // matches the pin at release and no false edge follows reset
    always_ff @(posedge aclk)
    begin
        meta <= {ext_irq1, ext_irq0};
        sync <= meta;
        prev <= sync;
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;

    // ------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------
    // ext_irq0 by selected direction, ext_irq1 on falling edge only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eif.ext0_event <= 1'b0;
            eif.ext1_event <= 1'b0;
        end
        else
        begin
            case (eif.edge_sel)
                `MIC_EDGE_RISE: eif.ext0_event <= rise[0];
                `MIC_EDGE_FALL: eif.ext0_event <= fall[0];
                `MIC_EDGE_BOTH: eif.ext0_event <= rise[0] | fall[0];
                default: eif.ext0_event <= 1'b0; // reserved code
            endcase
            eif.ext1_event <= fall[1];
        end
    end

endmodule // mic_edge_detect

/* test/mic_core_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// core sequencer stand-in
// ----------------------------------------
module mic_core_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    output logic insn_boundary
);
    logic [1:0] phase; // cycles since the last boundary
    // boundary every cycle, or only every third cycle when slow
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase <= 2'h0;
        else
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end
    assign insn_boundary = aresetn && (!slow || phase == 2'h0);
endmodule // mic_core_model

/* test/mic_irq_properties.sv */
`timescale 1ns/10ps
`include "mic_cfg.svh"
module mic_irq_properties
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic insn_boundary,
    input wire logic irq_return,
    input wire logic power_down,
    input wire logic green_mode,
    input wire logic ctx_restore,
    input wire logic restore_valid,
    input wire mic_pkg::mic_byte_t program_flag_reg_restore,
    input wire logic pc_load,
    input wire logic [`MIC_PC_W-1:0] pc_vector,
    input wire logic [`MIC_STK_HI:0] stack_level,
    input wire logic global_irq_enable,
    input wire logic wake_up
);
    import mic_pkg::*;
    // ----------------------------------------
    // vectoring checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_restore; // request then buffered values one cycle later
        ctx_restore ##1 restore_valid;
    endsequence
    chk_vector_addr: assert property (pc_load |-> pc_vector == `MIC_VECTOR)
        else $error("vector address wrong");
    chk_stack_push: assert property (pc_load |->
        stack_level == $past(stack_level) - 3'h1) else $error("stack not deeper");
    chk_gie_gate: assert property (pc_load |->
        $past(global_irq_enable) && !global_irq_enable)
        else $error("vector taken without global enable");
    chk_accept_cond: assert property (pc_load |->
        $past(insn_boundary && !power_down && !green_mode))
        else $error("vector taken off boundary or asleep");
    chk_return_gie: assert property (irq_return |=>
        global_irq_enable || pc_load) else $error("return left enable low");
    chk_pc_single: assert property (pc_load |=> !pc_load)
        else $error("vector pulse too long");
    chk_no_vec_sleep: assert property ($past(power_down) && power_down
        |-> !pc_load) else $error("vector while powered down");
    chk_wake_pulse: assert property (wake_up |=> !wake_up)
        else $error("wake pulse too long");
    // ----------------------------------------
    // save buffer checks
    // ----------------------------------------
    chk_restore_seq: assert property (ctx_restore |-> s_restore)
        else $error("restore not answered");
    chk_restore_mask: assert property (restore_valid |->
        program_flag_reg_restore[7:6] == 2'h0) else $error("reset-cause bits restored");
endmodule // mic_irq_properties
bind mic_interrupt_controller mic_irq_properties u_chk (.aclk, .aresetn,
    .insn_boundary, .irq_return, .power_down, .green_mode, .ctx_restore,
    .restore_valid, .program_flag_reg_restore, .pc_load, .pc_vector, .stack_level,
    .global_irq_enable, .wake_up);

/* test/tb.sv */
`timescale 1ns/10ps
`include "mic_cfg.svh"
module tb;
    import mic_pkg::*;
    localparam logic [11:0] A_EDGE = {`MIC_IDX_EDGE_SEL, 2'h0};
    localparam logic [11:0] A_FLAG = {`MIC_IDX_REQ_FLAGS, 2'h0};
    localparam logic [11:0] A_EN = {`MIC_IDX_ENABLE, 2'h0};
    localparam logic [11:0] A_STK = {`MIC_IDX_STACK_GIE, 2'h0};
    logic aclk = 0, aresetn = 0, slow = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, restore_valid, pc_load, insn_boundary;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ext_irq0 = 0, ext_irq1 = 1, timer0_ovf = 0, timer_counter0_ovf = 0;
    logic timer1_ovf = 0, irq_return = 0, power_down = 0, green_mode = 0;
    logic ctx_save = 0, ctx_restore = 0, global_irq_enable, wake_up;
    mic_byte_t acc_in = 0, program_flag_reg_in = 0, acc_restore, program_flag_reg_restore;
    logic [11:0] pc_vector;
    logic [2:0] stack_level;
    int failures = 0, cmp_count = 0, n_vec = 0, n_wake = 0;
    integer seed = 69675;
    logic [33:0] rq[$], sq[$]; // expected read answers, restored values
    logic [1:0] bq[$]; // expected write responses
    logic [15:0] e;
    mic_interrupt_controller DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq0,
        .ext_irq1, .timer0_ovf, .timer_counter0_ovf, .timer1_ovf,
        .insn_boundary, .irq_return, .power_down, .green_mode, .ctx_save,
        .ctx_restore, .acc_in, .program_flag_reg_in, .acc_restore, .program_flag_reg_restore,
        .restore_valid, .pc_load, .pc_vector, .stack_level,
        .global_irq_enable, .wake_up);
    mic_core_model u_core (.aclk, .aresetn, .slow, .insn_boundary);
    // ----------------------------------------
    // clock, checking and closing
    // ----------------------------------------
    initial
    begin
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watcher: outputs are settled at the falling edge
    always @(negedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (restore_valid)
            chk(34'({acc_restore, program_flag_reg_restore}), sq.pop_front());
        if (pc_load)
            n_vec++;
        if (wake_up)
            n_wake++;
    end
    // ----------------------------------------
    // bus and pin tasks
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r = 2'h0);
        bit aw, w, da, dw;
        int n;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        da = 0;
        dw = 0;
        for (n = 0; n < 100 && !(da && dw); n++)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            da |= aw;
            dw |= w;
        end
        for (n = 0; n < 100 && !s_axi_bvalid; n++)
            @(negedge aclk);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r = 2'h0);
        int n;
        rq.push_back({r, 24'h0, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(negedge aclk);
            if (s_axi_arready)
                break;
        end
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        for (n = 0; n < 100 && !s_axi_rvalid; n++)
            @(negedge aclk);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pin(input bit which, input bit v);
        @(posedge aclk);
        if (which)
            ext_irq1 <= v;
        else
            ext_irq0 <= v;
        repeat (8) @(posedge aclk);
    endtask
    task automatic ret;
        wr(A_FLAG, 8'h00);
        @(posedge aclk);
        irq_return <= 1'b1;
        @(posedge aclk);
        irq_return <= 1'b0;
    endtask
    task automatic sleep_wake(input bit pd, input int k);
        @(posedge aclk);
        power_down <= pd;
        green_mode <= !pd;
        pin(!pd, pd);
        chk(34'(n_wake), 34'(k));
        chk(34'(n_vec), 34'(k));
        @(posedge aclk);
        power_down <= 1'b0;
        green_mode <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(34'(n_vec), 34'(k + 1));
        ret();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        report_and_stop();
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_EDGE, 8'h10);
        rd(A_FLAG, 8'h00);
        rd(A_EN, 8'h00);
        rd(A_STK, 8'h07);
        rd(12'h000, 8'h00, `MIC_RESP_DECERR);
        wr(12'h000, 8'hff, `MIC_RESP_DECERR);
        s_axi_wstrb <= 4'h0;
        wr(A_EN, 8'h73);
        s_axi_wstrb <= 4'hf;
        rd(A_EN, 8'h00);
        @(posedge aclk);
        {timer0_ovf, timer_counter0_ovf, timer1_ovf} <= 3'h7;
        @(posedge aclk);
        {timer0_ovf, timer_counter0_ovf, timer1_ovf} <= 3'h0;
        rd(A_FLAG, 8'h70);
        wr(A_FLAG, 8'h00);
        rd(A_FLAG, 8'h00);
        pin(1, 0);
        rd(A_FLAG, 8'h02);
        wr(A_FLAG, 8'h00);
        pin(1, 1);
        rd(A_FLAG, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(A_EDGE, 8'(s << 3));
            pin(0, 1);
            rd(A_FLAG, 8'(s & 1));
            wr(A_FLAG, 8'h00);
            pin(0, 0);
            rd(A_FLAG, 8'(s >> 1));
            wr(A_FLAG, 8'h00);
        end
        slow <= 1'b1;
        wr(A_EN, 8'h10);
        @(posedge aclk);
        timer0_ovf <= 1'b1;
        @(posedge aclk);
        timer0_ovf <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(34'(n_vec), 34'h0);
        wr(A_STK, 8'h87);
        repeat (10) @(posedge aclk);
        chk(34'(n_vec), 34'h1);
        rd(A_STK, 8'h06);
        ret();
        rd(A_STK, 8'h87);
        pin(1, 0);
        pin(1, 1);
        chk(34'(n_vec), 34'h1);
        rd(A_FLAG, 8'h02);
        wr(A_FLAG, 8'h00);
        wr(A_EN, 8'h13);
        sleep_wake(0, 1);
        sleep_wake(1, 2);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge aclk);
            ctx_save <= 1'b1;
            e = 16'($random(seed));
            acc_in <= e[15:8];
            program_flag_reg_in <= e[7:0];
        end
        sq.push_back({18'h0, e[15:8], e[7:0] & `MIC_PROGRAM_FLAG_REG_KEEP});
        @(posedge aclk);
        ctx_save <= 1'b0;
        ctx_restore <= 1'b1;
        @(posedge aclk);
        ctx_restore <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(34'(sq.size()), 34'h0);
        report_and_stop();
    end
endmodule // tb
